// ---- src/rdt_top.sv ----
// APB register block with two reloading down timers
`timescale 1ns/1ps
`include "rdt_regs.svh"
module rdt_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        fast_tick,
  input  wire logic        uf_t0,
  input  wire logic        uf_t1,
  input  wire logic        tx_end,
  input  wire logic        rx_4bits,
  input  wire logic        lfo_clk_pin,
  output logic             irq
);
  import rdt_pkg::*;

  // ==========================================================
  // Register state
  rdt_ctl_s    t2_ctl_q;
  rdt_ctl_s    t3_ctl_q;
  logic [7:0]  t2_rel_hi_q;
  logic [7:0]  t2_rel_lo_q;
  logic [7:0]  t3_rel_hi_q;
  logic [7:0]  t3_rel_lo_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [5:0]  div_q;
  logic        tick64;
  logic        lfo_s;
  logic        lfo_prev_q;
  logic [15:0] t2_count;
  logic [15:0] t3_count;
  logic        t2_run;
  logic        t3_run;
  logic        t2_uf;
  logic        t3_uf;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic        hit;
  logic [7:0]  rdata;
  rdt_evt_s    evt;
  logic [1:0]  sw_start;
  logic [1:0]  sw_stop;

  // ==========================================================
  // APB decode, zero-wait answers
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite && clk_en;
  assign rd      = psel && penable && !pwrite && clk_en;
  assign idx     = paddr[9:2];
  assign pslverr = psel && penable && !hit;

  // ==========================================================
  // Trimming edge input through synchroniser
  rdt_sync u_lfo_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .din     (lfo_clk_pin),
    .dout    (lfo_s)
  );

  // Rising edge detect of synchronised trimming clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfo_prev_q <= 1'b0;
    end else if (clk_en) begin
      lfo_prev_q <= lfo_s;
    end
  end

  // Divide fast ticks by 64
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
    end else if (clk_en && fast_tick) begin
      div_q <= div_q + 6'h01;
    end
  end
  assign tick64 = fast_tick && div_q == `RDT_DIV64_MAX;

  assign evt.tx_end    = tx_end;
  assign evt.rx_4bits  = rx_4bits;
  assign evt.lfo_edge  = lfo_s && !lfo_prev_q;
  assign evt.uf_t0     = uf_t0;
  assign evt.uf_t1     = uf_t1;
  assign evt.fast_tick = fast_tick;

  // ==========================================================
  // Timers
  rdt_timer u_t2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .ctl       (t2_ctl_q),
    .reload    ({t2_rel_hi_q, t2_rel_lo_q}),
    .evt       (evt),
    .tick64    (tick64),
    .sw_start  (sw_start[0]),
    .sw_stop   (sw_stop[0]),
    .count_q   (t2_count),
    .running_q (t2_run),
    .underflow (t2_uf)
  );

  rdt_timer u_t3 (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .ctl       (t3_ctl_q),
    .reload    ({t3_rel_hi_q, t3_rel_lo_q}),
    .evt       (evt),
    .tick64    (tick64),
    .sw_start  (sw_start[1]),
    .sw_stop   (sw_stop[1]),
    .count_q   (t3_count),
    .running_q (t3_run),
    .underflow (t3_uf)
  );

  // Software start and stop strobes
  assign sw_start = (wr && idx == `RDT_IDX_START) ? pwdata[1:0] : 2'b00;
  assign sw_stop  = (wr && idx == `RDT_IDX_START) ? pwdata[5:4] : 2'b00;

  // ==========================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_ctl_q    <= rdt_ctl_s'(`RDT_RST_BYTE);
      t3_ctl_q    <= rdt_ctl_s'(`RDT_RST_BYTE);
      t2_rel_hi_q <= `RDT_RST_BYTE;
      t2_rel_lo_q <= `RDT_RST_BYTE;
      t3_rel_hi_q <= `RDT_RST_BYTE;
      t3_rel_lo_q <= `RDT_RST_BYTE;
      irq_mask_q  <= 2'b00;
    end else if (wr) begin
      unique case (idx)
        `RDT_IDX_T2_CONTROL:
          t2_ctl_q <= rdt_ctl_s'(pwdata[7:0] & `RDT_CTL_WMASK);
        `RDT_IDX_T3_CONTROL:
          t3_ctl_q <= rdt_ctl_s'(pwdata[7:0] & `RDT_CTL_WMASK);
        `RDT_IDX_T2_RELOAD_HI: t2_rel_hi_q <= pwdata[7:0];
        `RDT_IDX_T2_RELOAD_LO: t2_rel_lo_q <= pwdata[7:0];
        `RDT_IDX_T3_RELOAD_HI: t3_rel_hi_q <= pwdata[7:0];
        `RDT_IDX_T3_RELOAD_LO: t3_rel_lo_q <= pwdata[7:0];
        `RDT_IDX_IRQ_MASK:     irq_mask_q  <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky underflow flags; a read clears only the bits it reported
  // at setup, so a flag raised between setup and access is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'b00;
    end else if (clk_en) begin
      if (rd && idx == `RDT_IDX_IRQ_STATUS) begin
        irq_stat_q <= (irq_stat_q & ~prdata[1:0]) | {t3_uf, t2_uf};
      end else begin
        irq_stat_q <= irq_stat_q | {t3_uf, t2_uf};
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // Read mux
  always_comb begin
    hit   = 1'b1;
    rdata = 8'h00;
    unique case (idx)
      `RDT_IDX_T2_CONTROL:   rdata = t2_ctl_q;
      `RDT_IDX_T2_RELOAD_HI: rdata = t2_rel_hi_q;
      `RDT_IDX_T2_RELOAD_LO: rdata = t2_rel_lo_q;
      `RDT_IDX_T2_COUNT_HI:  rdata = t2_count[15:8];
      `RDT_IDX_T2_COUNT_LO:  rdata = t2_count[7:0];
      `RDT_IDX_T3_CONTROL:   rdata = t3_ctl_q;
      `RDT_IDX_T3_RELOAD_HI: rdata = t3_rel_hi_q;
      `RDT_IDX_T3_RELOAD_LO: rdata = t3_rel_lo_q;
      `RDT_IDX_T3_COUNT_HI:  rdata = t3_count[15:8];
      `RDT_IDX_T3_COUNT_LO:  rdata = t3_count[7:0];
      `RDT_IDX_IRQ_STATUS:   rdata = {6'h00, irq_stat_q};
      `RDT_IDX_IRQ_MASK:     rdata = {6'h00, irq_mask_q};
      `RDT_IDX_START:        rdata = {6'h00, t3_run, t2_run};
      default:               hit   = 1'b0;
    endcase
  end

  // Read data registered at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rdata};
    end
  end

  // ==========================================================
  // Checks
  property p_reload_hold;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_run && $past(t3_run) && !$past(sw_start[1])
      && $changed(t3_rel_lo_q)) |-> t3_count != {t3_rel_hi_q, t3_rel_lo_q}
      || $past(t3_count) == t3_count || $past(t3_count) - 16'h1 == t3_count;
  endproperty
  a_reload_hold: assert property (p_reload_hold)
    else $error("reload write disturbed count");

  property p_start_load;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && sw_start[1]) |=> t3_count == $past({t3_rel_hi_q, t3_rel_lo_q});
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start did not load reload");

  property p_stop_rx;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_run && rx_4bits && t3_ctl_q.stop_on_receive
      && !t3_ctl_q.start_mode_select[1] && !sw_start[1]
      && !tx_end) |=> !t3_run;
  endproperty
  a_stop_rx: assert property (p_stop_rx)
    else $error("stop on receive ignored");

  property p_uf_flag;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_uf) |=> irq_stat_q[1];
  endproperty
  a_uf_flag: assert property (p_uf_flag)
    else $error("underflow flag not set");

  property p_no_restart;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_uf && !t3_ctl_q.auto_reload_enable) |=> !t3_run;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("timer kept running at zero");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_uf && t3_ctl_q.auto_reload_enable) |=>
      t3_run && t3_count == $past({t3_rel_hi_q, t3_rel_lo_q});
  endproperty
  a_restart: assert property (p_restart)
    else $error("auto restart failed");

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
    !t3_ctl_q.rsvd6 && !t3_ctl_q.rsvd2;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");

  property p_dec;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_run && t3_count != 16'h0 && fast_tick && !sw_start[1]
      && !sw_stop[1] && !rx_4bits && !evt.lfo_edge && !tx_end
      && t3_ctl_q.input_clock_select == RDT_CLK_FAST)
      |=> t3_count == $past(t3_count) - 16'h1;
  endproperty
  a_dec: assert property (p_dec)
    else $error("count did not decrement");

  property p_t2_load;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && sw_start[0])
      |=> t2_count == $past({t2_rel_hi_q, t2_rel_lo_q});
  endproperty
  a_t2_load: assert property (p_t2_load)
    else $error("second timer start did not load reload");

  property p_tx_start;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_ctl_q.start_mode_select == RDT_START_TX_END && tx_end)
      |=> t3_run && t3_count == $past({t3_rel_hi_q, t3_rel_lo_q});
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("no start at end of transmission");

  property p_no_auto;
    @(posedge pclk) disable iff (!presetn)
    (t3_ctl_q.start_mode_select == RDT_START_NONE && !t3_run && !sw_start[1])
      |=> !t3_run;
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("timer started without a start source");

  property p_trim_start;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !t3_run && t3_ctl_q.start_mode_select[1] && evt.lfo_edge)
      |=> t3_run && t3_count == $past({t3_rel_hi_q, t3_rel_lo_q});
  endproperty
  a_trim_start: assert property (p_trim_start)
    else $error("trimming edge did not start timer");

  property p_trim_rx;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_run && t3_ctl_q.start_mode_select[1] && rx_4bits
      && !evt.lfo_edge && !sw_stop[1] && !t3_uf) |=> t3_run;
  endproperty
  a_trim_rx: assert property (p_trim_rx)
    else $error("receive stopped a trimming timer");

  property p_cascade;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && t3_run && t3_count != 16'h0000 && !sw_start[1]
      && !sw_stop[1] && !rx_4bits && !evt.lfo_edge && !tx_end
      && ((t3_ctl_q.input_clock_select == RDT_CLK_UF_T0 && uf_t0)
      || (t3_ctl_q.input_clock_select == RDT_CLK_UF_T1 && uf_t1)))
      |=> t3_count == $past(t3_count) - 16'h0001;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascaded underflow did not decrement");
endmodule

// ---- inc/rdt_regs.svh ----
// Register offsets, field positions, reset values for the timer pair
`ifndef RDT_REGS_SVH
`define RDT_REGS_SVH
// Register indices (byte address is four times the index)
`define RDT_IDX_T2_RELOAD_LO   8'h1B
`define RDT_IDX_T2_COUNT_HI    8'h1C
`define RDT_IDX_T2_COUNT_LO    8'h1D
`define RDT_IDX_T3_CONTROL     8'h1E
`define RDT_IDX_T3_RELOAD_HI   8'h1F
`define RDT_IDX_T3_RELOAD_LO   8'h20
`define RDT_IDX_T3_COUNT_HI    8'h21
`define RDT_IDX_T3_COUNT_LO    8'h22
`define RDT_IDX_T2_CONTROL     8'h40
`define RDT_IDX_T2_RELOAD_HI   8'h41
`define RDT_IDX_IRQ_STATUS     8'h42
`define RDT_IDX_IRQ_MASK       8'h43
`define RDT_IDX_START          8'h44
// Control field positions
`define RDT_CTL_STOP_RX        7
`define RDT_CTL_START_HI       5
`define RDT_CTL_START_LO       4
`define RDT_CTL_AUTO_RELOAD    3
`define RDT_CTL_CLK_HI         1
`define RDT_CTL_CLK_LO         0
`define RDT_CTL_WMASK          8'hBB
// Reset values
`define RDT_RST_BYTE           8'h00
`define RDT_RST_COUNT          16'h0000
// Prescaler for the one-sixty-fourth rate
`define RDT_DIV64_MAX          6'h3F
`endif

// ---- inc/rdt_pkg.sv ----
// Types shared by the timer pair
package rdt_pkg;
  typedef enum logic [1:0] {
    RDT_START_NONE,
    RDT_START_TX_END,
    RDT_START_TRIM,
    RDT_START_TRIM_UF
  } rdt_start_e;
  typedef enum logic [1:0] {
    RDT_CLK_FAST,
    RDT_CLK_DIV64,
    RDT_CLK_UF_T0,
    RDT_CLK_UF_T1
  } rdt_clk_e;
  // Control byte of one timer
  typedef struct packed {
    logic       stop_on_receive;
    logic       rsvd6;
    rdt_start_e start_mode_select;
    logic       auto_reload_enable;
    logic       rsvd2;
    rdt_clk_e   input_clock_select;
  } rdt_ctl_s;
  // Events feeding the timers
  typedef struct packed {
    logic tx_end;
    logic rx_4bits;
    logic lfo_edge;
    logic uf_t0;
    logic uf_t1;
    logic fast_tick;
  } rdt_evt_s;
endpackage

// ---- src/rdt_sync.sv ----
// Three-stage synchroniser for a pin level
`timescale 1ns/1ps
module rdt_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Shift chain, the change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else if (clk_en) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// ---- src/rdt_timer.sv ----
// One 16-bit reloading down counter
`timescale 1ns/1ps
`include "rdt_regs.svh"
module rdt_timer (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire rdt_pkg::rdt_ctl_s ctl,
  input  wire logic [15:0]   reload,
  input  wire rdt_pkg::rdt_evt_s evt,
  input  wire logic          tick64,
  input  wire logic          sw_start,
  input  wire logic          sw_stop,
  output logic [15:0]        count_q,
  output logic               running_q,
  output logic               underflow
);
  import rdt_pkg::*;
  logic tick;
  logic trim;
  logic start_evt;
  logic stop_evt;
  // Tick source per clock select
  always_comb begin
    unique case (ctl.input_clock_select)
      RDT_CLK_FAST:  tick = evt.fast_tick;
      RDT_CLK_DIV64: tick = tick64;
      RDT_CLK_UF_T0: tick = evt.uf_t0;
      RDT_CLK_UF_T1: tick = evt.uf_t1;
    endcase
  end
  assign trim = ctl.start_mode_select[1];
  // Start sources: software, end of transmission, trimming edge
  assign start_evt = sw_start
    | (ctl.start_mode_select == RDT_START_TX_END && evt.tx_end)
    | (trim && evt.lfo_edge && !running_q);
  // Stop sources; receive stop ignored in trimming modes
  assign stop_evt = sw_stop
    | (ctl.stop_on_receive && !trim && evt.rx_4bits)
    | (trim && evt.lfo_edge && running_q);
  assign underflow = running_q && !start_evt && !stop_evt && tick
    && count_q == 16'h0000
    && ctl.start_mode_select != RDT_START_TRIM;
  // Counter and run state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= `RDT_RST_COUNT;
      running_q <= 1'b0;
    end else if (clk_en) begin
      if (start_evt) begin
        count_q   <= reload;
        running_q <= 1'b1;
      end else if (stop_evt) begin
        running_q <= 1'b0;
      end else if (running_q && tick) begin
        if (count_q != 16'h0000) begin
          count_q <= count_q - 16'h0001;
        end else if (ctl.start_mode_select == RDT_START_TRIM) begin
          running_q <= 1'b1;
        end else if (ctl.auto_reload_enable) begin
          count_q <= reload;
        end else begin
          running_q <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the reloading down timer pair
`timescale 1ns/1ps
`include "rdt_regs.svh"
module tb;
  import rdt_pkg::*;
  typedef struct {
    string       nm;
    logic [32:0] v;
  } rdt_exp_s;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [4:0]  ev;
  logic        low_freq_oscillator;
  logic        irq;
  rdt_exp_s    q[$];
  rdt_exp_s    e;
  int          bad_count;
  int          n_tests;
  int          t;
  int          m;
  logic [15:0] r;
  logic [15:0] r2;
  localparam logic [7:0] st_i = `RDT_IDX_START;
  localparam logic [7:0] is_i = `RDT_IDX_IRQ_STATUS;
  localparam logic [7:0] ci[2] = '{`RDT_IDX_T2_CONTROL, `RDT_IDX_T3_CONTROL};
  localparam logic [7:0] hi[2] = '{`RDT_IDX_T2_RELOAD_HI,
                                   `RDT_IDX_T3_RELOAD_HI};
  localparam logic [7:0] lo[2] = '{`RDT_IDX_T2_RELOAD_LO,
                                   `RDT_IDX_T3_RELOAD_LO};
  localparam logic [7:0] ch[2] = '{`RDT_IDX_T2_COUNT_HI, `RDT_IDX_T3_COUNT_HI};
  localparam logic [7:0] cl[2] = '{`RDT_IDX_T2_COUNT_LO, `RDT_IDX_T3_COUNT_LO};
  localparam logic [15:0] dec[4] = '{16'h0000, 16'h0002, 16'h0003, 16'h0005};
  localparam logic [7:0] rst_i[10] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F,
                                       8'h20, 8'h21, 8'h22, 8'h42, 8'h43};

  rdt_top u_dut (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .prdata      (prdata),
    .fast_tick   (ev[0]),
    .uf_t0       (ev[1]),
    .uf_t1       (ev[2]),
    .tx_end      (ev[3]),
    .rx_4bits    (ev[4]),
    .lfo_clk_pin (low_freq_oscillator),
    .irq         (irq)
  );

  // Clock
  always #5 pclk = ~pclk;

  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [32:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Setup, access until pready, release, then one idle edge
  task automatic apb(input logic w, input logic [7:0] idx, wd,
                     input string nm, input logic [32:0] exp);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 12'({idx, 2'b00});
    pwdata <= {24'h000000, wd};
    if (!w) q.push_back('{nm, exp});
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, d);
    apb(1'b1, idx, d, "", 33'h000000000);
  endtask

  task automatic rd(input string nm, input logic [7:0] idx, exp);
    apb(1'b0, idx, 8'h00, nm, {25'h0000000, exp});
  endtask

  // Count read as high byte, then low byte
  task automatic cnt(input int k, input logic [15:0] x);
    rd("count_high", ch[k], x[15:8]);
    rd("count_low", cl[k], x[7:0]);
  endtask

  task automatic pulse(input int b, input int n);
    repeat (n) begin
      ev[b] <= 1'b1;
      @(posedge pclk);
      ev[b] <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic lfo_edge;
    low_freq_oscillator <= 1'b1;
    repeat (8) @(posedge pclk);
    low_freq_oscillator <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  // Stop both timers, then program control and reload
  task automatic setup(input int k, input logic [7:0] c, input logic [15:0] x);
    wr(st_i, 8'h30);
    wr(ci[k], c);
    wr(hi[k], x[15:8]);
    wr(lo[k], x[7:0]);
  endtask

  // Compare each read answer with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      chk(e.nm, {pslverr, prdata}, e.v);
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ev = 5'h00;
    low_freq_oscillator = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'hB189));
    @(posedge pclk);
    // Reset values
    foreach (rst_i[k]) rd("reset", rst_i[k], 8'h00);
    // Reload bytes read back, frozen write, reserved bits, unmapped
    for (t = 0; t < 2; t++) begin
      r = 16'($urandom);
      wr(lo[t], r[7:0]);
      wr(hi[t], r[15:8]);
      rd("reload_low", lo[t], r[7:0]);
      rd("reload_high", hi[t], r[15:8]);
    end
    clk_en <= 1'b0;
    wr(lo[1], ~r[7:0]);
    clk_en <= 1'b1;
    rd("frozen", lo[1], r[7:0]);
    wr(ci[1], 8'hFF);
    rd("control", ci[1], 8'hBB);
    apb(1'b0, 8'h30, 8'h00, "unmapped", {1'b1, 32'h00000000});
    // Countdown, reload writes deferred to next start
    for (t = 0; t < 2; t++) begin
      r = {8'($urandom_range(255, 1)), 8'($urandom)};
      r2 = r ^ 16'h00F0;
      setup(t, 8'h00, r);
      wr(st_i, 8'(1 << t));
      pulse(0, 5);
      cnt(t, r - 16'h0005);
      wr(lo[t], r2[7:0]);
      wr(hi[t], r2[15:8]);
      pulse(0, 3);
      cnt(t, r - 16'h0008);
      wr(st_i, 8'h30);
      wr(st_i, 8'(1 << t));
      cnt(t, r2);
    end
    // Input clock choices
    for (m = 1; m < 4; m++) begin
      r = {8'($urandom_range(255, 1)), 8'($urandom)};
      setup(1, 8'(m), r);
      wr(st_i, 8'h02);
      pulse(0, 128);
      pulse(1, 3);
      pulse(2, 5);
      cnt(1, r - dec[m]);
    end
    // Underflow, interrupt mask, auto restart
    for (m = 0; m < 2; m++) begin
      wr(`RDT_IDX_IRQ_MASK, 8'(m * 2));
      setup(1, 8'(m << 3), 16'h0002);
      wr(st_i, 8'h02);
      pulse(0, 3);
      @(posedge pclk);
      chk("irq", 33'(irq), 33'(m));
      rd("status", is_i, 8'h02);
      rd("status_clear", is_i, 8'h00);
      chk("irq_clear", 33'(irq), 33'h000000000);
      rd("running", st_i, 8'(m * 2));
    end
    cnt(1, 16'h0002);
    pulse(0, 1);
    cnt(1, 16'h0001);
    // Start at end of transmission, stop on receive
    for (m = 0; m < 4; m++) begin
      setup(1, {m[1], 2'b00, m[0], 4'h0}, 16'h0100);
      pulse(3, 1);
      pulse(0, 1);
      pulse(4, 1);
      pulse(0, 2);
      rd("running", st_i, 8'((m == 1) * 2));
      if (m[0]) cnt(1, m[1] ? 16'h00FF : 16'h00FD);
    end
    // Trimming modes: edges start and stop, receive ignored
    for (m = 2; m < 4; m++) begin
      setup(1, 8'(8'h80 | (m << 4)), 16'h0100);
      lfo_edge();
      rd("trim_run", st_i, 8'h02);
      pulse(4, 1);
      rd("trim_rx", st_i, 8'h02);
      lfo_edge();
      rd("trim_stop", st_i, 8'h00);
    end
    chk("pending", 33'(q.size()), 33'h000000000);
    end_of_test();
  end
endmodule
